// [pkg/fsr_pkg.sv]
// Purpose: shared constants and types of the flash status register bank
// Assumes: serial link in modes 0 and 3, system clock CLK at 125 MHz
// Notes: bit positions index an 8-bit status byte; byte 1 is sent first
package fsr_pkg;
  // ********************************
  // opcodes
  // ********************************
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_WRITE_STATUS2 = 8'h31;

  // ********************************
  // field positions
  // ********************************
  localparam int SR_WIDTH = 16;
  localparam int SR1_LOCK = 7;
  localparam int SR1_FAIL = 5;
  localparam int SR1_PIN = 4;
  localparam int SR1_PROTECT = 2;
  localparam int SR1_LATCH = 1;
  localparam int SR_BUSY = 0;
  localparam int SR2_RESET_CMD_ENABLE = 4;
  localparam int WD_LOCK = 7;
  localparam int WD_PROTECT = 2;
  localparam int WD2_RESET_CMD_ENABLE = 4;

  // ********************************
  // reset values
  // ********************************
  localparam logic LOCK_RST = 1'b0;
  localparam logic PROTECT_RST = 1'b0;
  localparam logic FAIL_RST = 1'b0;
  localparam logic LATCH_RST = 1'b0;
  localparam logic RESET_CMD_ENABLE_RST = 1'b0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {PH_OPCODE, PH_DATA, PH_EXTRA} fsr_phase_t;
endpackage

// [pkg/fsr_wsr_if.sv]
// Purpose: carrier between the status bank and the write status evaluator
// Assumes: evaluator is purely combinational
// Notes: bank drives the current state, evaluator answers with next values
`timescale 1ns/1ps
interface fsr_wsr_if;
  logic lock_cur;
  logic protect_cur;
  logic wp_asserted;
  logic [7:0] data;
  logic lock_new;
  logic protect_new;
  logic refused;
  modport bank (output lock_cur, protect_cur, wp_asserted, data,
                input lock_new, protect_new, refused);
  modport eval (input lock_cur, protect_cur, wp_asserted, data,
                output lock_new, protect_new, refused);
endinterface

// [hdl/fsr_sync.sv]
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is an independent level
// Notes: bits of a word may land one edge apart; only use for independent levels
`timescale 1ns/1ps
module fsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] out;
  } fsr_sync_t;

  fsr_sync_t s_reg;
  fsr_sync_t s_next;

  always_comb begin
    s_next.meta = d;
    s_next.out = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= {RST_VAL, RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.out;
endmodule

// [hdl/fsr_wsr_eval.sv]
// Purpose: decides the outcome of a write status data byte
// Assumes: caller has already checked the write latch and byte framing
// Notes: prior lock and pin state decide, not the new lock value
`timescale 1ns/1ps
module fsr_wsr_eval (
  // bank side
  fsr_wsr_if.eval w
);
  logic frozen;

  always_comb begin
    frozen = w.lock_cur && w.wp_asserted;
    // clearing the lock under an asserted pin drops the whole command
    w.refused = frozen && !w.data[fsr_pkg::WD_LOCK];
    w.lock_new = w.refused ? w.lock_cur : w.data[fsr_pkg::WD_LOCK];
    w.protect_new = frozen ? w.protect_cur : w.data[fsr_pkg::WD_PROTECT];
  end
endmodule

// [hdl/fsr_top.sv]
// Purpose: status register bank and status read path of a serial flash
// Assumes: SCK from the host; CLK runs free; core events are CLK-domain pulses
// Notes: chip select must stay high at least 4 CLK cycles between frames
`timescale 1ns/1ps
module fsr_top (
  // system clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // serial link from the host
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  // write protect pin, low when asserted
  input wire logic WP_N,
  // flash core events
  input wire logic CORE_BUSY,
  input wire logic OP_DONE,
  input wire logic OP_FAIL,
  input wire logic LATCH_SET,
  input wire logic LATCH_CLEAR,
  input wire logic SOFT_RESET,
  // status toward the core
  output logic PROTECT_LOCK,
  output logic ARRAY_PROTECT,
  output logic ERASE_PROGRAM_FAIL,
  output logic WRITE_LATCH,
  output logic RESET_CMD_ENABLE,
  output logic READY_BUSY
);

  // ********************************
  // state types
  // ********************************
  typedef struct packed {
    logic seq;
    logic [2:0] bit_cnt;
    fsr_pkg::fsr_phase_t phase;
    logic [6:0] shift;
    logic [7:0] opcode;
    logic [7:0] data;
  } fsr_rise_t;

  typedef struct packed {
    logic [3:0] out_cnt;
    logic so;
    logic so_oe;
  } fsr_fall_t;

  typedef struct packed {
    logic cs_prev;
    logic seq_seen;
    logic lock;
    logic protect;
    logic fail;
    logic pin_state;
    logic latch;
    logic reset_cmd_enable;
    logic busy;
  } fsr_core_t;

  // ********************************
  // helpers
  // ********************************
  // a data byte counts only when whole and chip select rose on a byte boundary
  function automatic logic frame_full(input fsr_pkg::fsr_phase_t ph,
                                      input logic [2:0] cnt);
    frame_full = (ph == fsr_pkg::PH_EXTRA) && (cnt == 3'h0);
  endfunction

  function automatic logic [fsr_pkg::SR_WIDTH-1:0] pack_status(input fsr_core_t s);
    logic [7:0] b1;
    logic [7:0] b2;
    b1 = 8'h00;
    b2 = 8'h00;
    b1[fsr_pkg::SR1_LOCK] = s.lock;
    b1[fsr_pkg::SR1_FAIL] = s.fail;
    b1[fsr_pkg::SR1_PIN] = s.pin_state;
    b1[fsr_pkg::SR1_PROTECT] = s.protect;
    b1[fsr_pkg::SR1_LATCH] = s.latch;
    b1[fsr_pkg::SR_BUSY] = s.busy;
    b2[fsr_pkg::SR2_RESET_CMD_ENABLE] = s.reset_cmd_enable;
    b2[fsr_pkg::SR_BUSY] = s.busy;
    // reserved positions stay at zero from the initial clear
    pack_status = {b1, b2};
  endfunction

  // ********************************
  // declarations
  // ********************************
  fsr_rise_t r_reg;
  fsr_rise_t r_next;
  fsr_fall_t f_reg;
  fsr_fall_t f_next;
  fsr_core_t c_reg;
  fsr_core_t c_next;
  logic fresh_reg;
  logic frame_rst_n;
  logic [7:0] byte_in;
  logic read_on;
  logic [fsr_pkg::SR_WIDTH-1:0] status_clk;
  logic [fsr_pkg::SR_WIDTH-1:0] status_sck;
  logic cs_sync;
  logic seq_sync;
  logic wp_sync;
  logic frame_end;
  logic opcode_full;
  logic wr1;
  logic wr2;
  logic cmd_ok;

  fsr_wsr_if wsr ();

  // ********************************
  // link domain: receive on rising SCK
  // ********************************
  // frame reset kills the output as soon as chip select rises, even mid-byte
  assign frame_rst_n = RESETN & ~CS_N;

  // marks the first rising edge of a frame; set while deselected
  always_ff @(posedge SCK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_comb begin
    r_next = r_reg;
    byte_in = {r_reg.shift, SI};
    if (CS_N) begin
      // edges while deselected belong to another device sharing the link
      r_next = r_reg;
    end else if (fresh_reg) begin
      // toggle tells the CLK side that this frame carried clocks
      r_next.seq = ~r_reg.seq;
      r_next.bit_cnt = 3'h1;
      r_next.phase = fsr_pkg::PH_OPCODE;
      r_next.shift = {6'h00, SI};
    end else begin
      r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
      r_next.shift = byte_in[6:0];
      if (r_reg.bit_cnt == fsr_pkg::BIT_LAST) begin
        unique case (r_reg.phase)
          fsr_pkg::PH_OPCODE: begin
            r_next.opcode = byte_in;
            r_next.phase = fsr_pkg::PH_DATA;
          end
          fsr_pkg::PH_DATA: begin
            // later bytes are ignored, only the first data byte is kept
            r_next.data = byte_in;
            r_next.phase = fsr_pkg::PH_EXTRA;
          end
          fsr_pkg::PH_EXTRA: begin
            r_next.phase = fsr_pkg::PH_EXTRA;
          end
          default: begin
            r_next.phase = fsr_pkg::PH_EXTRA;
          end
        endcase
      end
    end
  end

  // fields are kept after the frame so the CLK side can read them at rest
  always_ff @(posedge SCK or negedge RESETN) begin
    if (!RESETN) begin
      r_reg <= '{seq: 1'b0, bit_cnt: 3'h0, phase: fsr_pkg::PH_OPCODE,
                 shift: 7'h00, opcode: 8'h00, data: 8'h00};
    end else begin
      r_reg <= r_next;
    end
  end

  // ********************************
  // link domain: transmit on falling SCK
  // ********************************
  // live status, resampled on every rising SCK
  fsr_sync #(
    .WIDTH(fsr_pkg::SR_WIDTH),
    .RST_VAL(16'h0000)
  ) u_status_sync (
    .clk(SCK),
    .rst_n(RESETN),
    .d(status_clk),
    .q(status_sck)
  );

  always_comb begin
    f_next = f_reg;
    // fresh gates out a stale opcode before the first rising edge in mode 3
    read_on = !fresh_reg && (r_reg.phase != fsr_pkg::PH_OPCODE) &&
              (r_reg.opcode == fsr_pkg::OPC_READ_STATUS);
    if (read_on) begin
      f_next.so_oe = 1'b1;
      // inverted count walks 15 down to 0, then wraps to byte 1 again
      f_next.so = status_sck[~f_reg.out_cnt];
      f_next.out_cnt = f_reg.out_cnt + 4'h1;
    end
  end

  always_ff @(negedge SCK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f_reg <= '{out_cnt: 4'h0, so: 1'b0, so_oe: 1'b0};
    end else begin
      f_reg <= f_next;
    end
  end

  assign SO = f_reg.so;
  assign SO_OE = f_reg.so_oe;

  // ********************************
  // CLK domain: inputs
  // ********************************
  fsr_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_cs_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .d(CS_N),
    .q(cs_sync)
  );

  fsr_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_seq_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .d(r_reg.seq),
    .q(seq_sync)
  );

  fsr_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_wp_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .d(WP_N),
    .q(wp_sync)
  );

  // ********************************
  // CLK domain: write status evaluation
  // ********************************
  assign wsr.lock_cur = c_reg.lock;
  assign wsr.protect_cur = c_reg.protect;
  assign wsr.wp_asserted = ~wp_sync;
  assign wsr.data = r_reg.data;

  fsr_wsr_eval u_eval (
    .w(wsr)
  );

  // ********************************
  // CLK domain: status bank
  // ********************************
  always_comb begin
    c_next = c_reg;
    c_next.cs_prev = cs_sync;
    c_next.busy = CORE_BUSY;
    c_next.pin_state = wp_sync;
    // link fields are quiet here: SCK stopped once chip select rose
    frame_end = cs_sync && !c_reg.cs_prev && (seq_sync != c_reg.seq_seen);
    opcode_full = r_reg.phase != fsr_pkg::PH_OPCODE;
    wr1 = frame_end && opcode_full && (r_reg.opcode == fsr_pkg::OPC_WRITE_STATUS);
    wr2 = frame_end && opcode_full && (r_reg.opcode == fsr_pkg::OPC_WRITE_STATUS2);
    cmd_ok = frame_full(r_reg.phase, r_reg.bit_cnt) && c_reg.latch;
    if (cs_sync && !c_reg.cs_prev) begin
      c_next.seq_seen = seq_sync;
    end
    if (wr1 && cmd_ok && !wsr.refused) begin
      c_next.lock = wsr.lock_new;
      c_next.protect = wsr.protect_new;
    end
    if (wr2 && cmd_ok && frame_full(r_reg.phase, r_reg.bit_cnt)) begin
      c_next.reset_cmd_enable = r_reg.data[fsr_pkg::WD2_RESET_CMD_ENABLE];
    end
    if (OP_DONE) begin
      c_next.fail = OP_FAIL;
    end
    // a write status that got its whole opcode clears the latch either way
    if (wr1 || wr2 || LATCH_CLEAR || SOFT_RESET) begin
      c_next.latch = 1'b0;
    end
    if (LATCH_SET) begin
      c_next.latch = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      c_reg <= '{cs_prev: 1'b1, seq_seen: 1'b0, lock: fsr_pkg::LOCK_RST,
                 protect: fsr_pkg::PROTECT_RST, fail: fsr_pkg::FAIL_RST,
                 pin_state: 1'b1, latch: fsr_pkg::LATCH_RST,
                 reset_cmd_enable: fsr_pkg::RESET_CMD_ENABLE_RST, busy: 1'b0};
    end else begin
      c_reg <= c_next;
    end
  end

  assign status_clk = pack_status(c_reg);

  // ********************************
  // outputs toward the core
  // ********************************
  assign PROTECT_LOCK = c_reg.lock;
  // core must refuse program and erase while this is high
  assign ARRAY_PROTECT = c_reg.protect;
  assign ERASE_PROGRAM_FAIL = c_reg.fail;
  // core must reject write commands while this is low
  assign WRITE_LATCH = c_reg.latch;
  assign RESET_CMD_ENABLE = c_reg.reset_cmd_enable;
  assign READY_BUSY = c_reg.busy;
endmodule

// [bench/fsr_asserts.sv]
// Purpose: port checks of the status register bank
// Assumes: one CLK domain, RESETN asynchronous active low
// Notes: link bit timing is judged by the bench
`timescale 1ns/1ps
module fsr_asserts (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // link
  input wire logic CS_N,
  input wire logic SO,
  input wire logic SO_OE,
  // pin and core events
  input wire logic WP_N,
  input wire logic OP_DONE,
  input wire logic OP_FAIL,
  input wire logic LATCH_SET,
  input wire logic LATCH_CLEAR,
  input wire logic SOFT_RESET,
  // status
  input wire logic PROTECT_LOCK,
  input wire logic ARRAY_PROTECT,
  input wire logic ERASE_PROGRAM_FAIL,
  input wire logic WRITE_LATCH,
  input wire logic RESET_CMD_ENABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ****************
  // sequences
  // ****************
  // five cycles let the pin synchroniser agree with the pin
  sequence pin_locked;
    (!WP_N && PROTECT_LOCK) [*5];
  endsequence
  sequence clear_only;
    (LATCH_CLEAR || SOFT_RESET) && !LATCH_SET;
  endsequence
  // ****************
  // properties
  // ****************
  reset_val_a: assert property (
    $rose(RESETN) |-> !(PROTECT_LOCK || WRITE_LATCH || RESET_CMD_ENABLE))
    else $error("status not cleared at reset");
  fail_load_a: assert property (OP_DONE |=> ERASE_PROGRAM_FAIL == $past(OP_FAIL))
    else $error("fail bit not loaded");
  fail_hold_a: assert property (!OP_DONE |=> $stable(ERASE_PROGRAM_FAIL))
    else $error("fail bit moved without completion");
  latch_clear_a: assert property (clear_only |=> !WRITE_LATCH)
    else $error("write latch not cleared");
  latch_rise_a: assert property ($rose(WRITE_LATCH) |-> $past(LATCH_SET))
    else $error("write latch set without cause");
  out_float_a: assert property (CS_N |-> !SO_OE && !SO)
    else $error("serial output driven while deselected");
  lock_frozen_a: assert property (
    pin_locked |=> PROTECT_LOCK && $stable(ARRAY_PROTECT))
    else $error("locked protect bit changed");
  write_quiet_a: assert property (
    $changed({PROTECT_LOCK, ARRAY_PROTECT, RESET_CMD_ENABLE}) |-> $past(CS_N))
    else $error("status write outside a closed frame");
endmodule
bind fsr_top fsr_asserts u_chk (.CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .SO(SO),
  .SO_OE(SO_OE), .WP_N(WP_N), .OP_DONE(OP_DONE), .OP_FAIL(OP_FAIL),
  .LATCH_SET(LATCH_SET), .LATCH_CLEAR(LATCH_CLEAR), .SOFT_RESET(SOFT_RESET),
  .PROTECT_LOCK(PROTECT_LOCK), .ARRAY_PROTECT(ARRAY_PROTECT),
  .ERASE_PROGRAM_FAIL(ERASE_PROGRAM_FAIL), .WRITE_LATCH(WRITE_LATCH),
  .RESET_CMD_ENABLE(RESET_CMD_ENABLE));

// [bench/fsr_host.sv]
// Purpose: host side of the serial link for the status bank bench
// Assumes: mode 0 or 3 as cpol says, idle clock level changed only while deselected
// Notes: link clock period 6 ns, stopped outside frames
`timescale 1ns/1ps
module fsr_host (
  // link
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic oe_any;
  logic cpol;
  initial begin
    cpol = 1'h0;
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
    oe_any = 1'h0;
  end
  // ****************
  // one frame, bits sent from tx[31] down
  // ****************
  task automatic frame(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = 32'h0;
    oe_any = 1'h0;
    // idle level moves ahead of the frame so no edge meets the chip select edge
    if (sck !== cpol) begin
      sck = cpol;
      #2;
    end
    cs_n = 1'h0;
    for (int i = 0; i < nb; i++) begin
      #2 sck = 1'h0;
      si = (i < 32) ? tx[31-i] : 1'h0;
      #1 sck = 1'h1;
      // an undriven line shows the inverse of the last bit, never a held value
      rx = {rx[30:0], so_oe ? so : ~rx[0]};
      oe_any = oe_any | so_oe;
      #3 sck = cpol;
    end
    #3 cs_n = 1'h1;
    // a released line must not look held
    si = ~si;
    // gap covers frame sync and status update in the core clock
    #64;
  endtask
endmodule

// [bench/fsr_top_tb.sv]
// Purpose: self-checking bench of the status register bank
// Assumes: host model drives the link, core events driven here
// Notes: expected status comes from the bench model bits
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module fsr_top_tb;
  // ****************
  // signals and model
  // ****************
  logic CLK, RESETN, WP_N, CORE_BUSY, OP_DONE, OP_FAIL, LATCH_SET, LATCH_CLEAR, SOFT_RESET;
  logic SCK, CS_N, SI, SO, SO_OE, PROTECT_LOCK, ARRAY_PROTECT, ERASE_PROGRAM_FAIL;
  logic WRITE_LATCH, RESET_CMD_ENABLE, READY_BUSY;
  logic lock, prot, fail, latch, rst_en, busy;
  logic [7:0] d;
  logic [31:0] rx;
  int errors, checked, cycles, seed;
  // pin, latch set, opcode, data, bit count
  logic [31:0] cases [10] = '{32'h10018410, 32'h11018410, 32'h01010010, 32'h01018010,
    32'h11010410, 32'h01018010, 32'h11017B0D, 32'h11010005, 32'h11311010, 32'h1101FF18};
  logic [4:0] corner [5] = '{5'h06, 5'h01, 5'h18, 5'h08, 5'h10};
  fsr_top dut (.CLK(CLK), .RESETN(RESETN), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
    .SO_OE(SO_OE), .WP_N(WP_N), .CORE_BUSY(CORE_BUSY), .OP_DONE(OP_DONE),
    .OP_FAIL(OP_FAIL), .LATCH_SET(LATCH_SET), .LATCH_CLEAR(LATCH_CLEAR),
    .SOFT_RESET(SOFT_RESET), .PROTECT_LOCK(PROTECT_LOCK), .ARRAY_PROTECT(ARRAY_PROTECT),
    .ERASE_PROGRAM_FAIL(ERASE_PROGRAM_FAIL), .WRITE_LATCH(WRITE_LATCH),
    .RESET_CMD_ENABLE(RESET_CMD_ENABLE), .READY_BUSY(READY_BUSY));
  fsr_host host (.sck(SCK), .cs_n(CS_N), .si(SI), .so(SO), .so_oe(SO_OE));
  initial begin
    CLK = 1'h0;
    forever #4 CLK = ~CLK;
  end
  // ****************
  // expectation and stimulus
  // ****************
  function automatic logic [15:0] sr();
    return {lock, 1'h0, fail, WP_N, 1'h0, prot, latch, busy, 3'h0, rst_en, 3'h0, busy};
  endfunction
  function automatic void wsr(input logic [7:0] op, input logic [7:0] dv, input int nb);
    if (nb < 8 || (op != fsr_pkg::OPC_WRITE_STATUS && op != 8'h31)) return;
    if (latch && nb >= 16 && nb % 8 == 0) begin
      if (op == 8'h31) rst_en = dv[4];
      else if (!(lock && !WP_N)) {lock, prot} = {dv[7], dv[2]};
    end
    latch = 1'h0;
  endfunction
  task automatic ev(input logic [4:0] v, input logic w);
    @(posedge CLK);
    #1 {OP_DONE, OP_FAIL, LATCH_SET, LATCH_CLEAR, SOFT_RESET} = v;
    WP_N = w;
    @(posedge CLK);
    #1 {OP_DONE, LATCH_SET, LATCH_CLEAR, SOFT_RESET} = 4'h0;
    if (v[4]) fail = v[3];
    if (v[2]) latch = 1'h1;
    else if (v[1] | v[0]) latch = 1'h0;
    repeat (2) @(posedge CLK);
  endtask
  task automatic rd(input string n);
    logic [15:0] e1, e2;
    @(posedge CLK);
    #1 e1 = sr();
    fork
      host.frame({fsr_pkg::OPC_READ_STATUS, 24'h0}, 40, rx);
      begin
        repeat (17) @(posedge CLK);
        // busy flips between the two copies while the host keeps clocking
        #1 CORE_BUSY = ~CORE_BUSY;
      end
    join
    busy = CORE_BUSY;
    e2 = sr();
    `CHK({n, " first"}, e1, rx[31:16]);
    `CHK({n, " again"}, e2, rx[15:0]);
    `CHK({n, " oe"}, 1'h1, host.oe_any);
    `CHK({n, " float"}, 2'h0, {SO_OE, SO});
    `CHK({n, " bits"}, {lock, prot, fail, latch, rst_en, busy}, {PROTECT_LOCK,
      ARRAY_PROTECT, ERASE_PROGRAM_FAIL, WRITE_LATCH, RESET_CMD_ENABLE, READY_BUSY});
  endtask
  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      close_out();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 10;
    {RESETN, WP_N, CORE_BUSY, OP_DONE, OP_FAIL, LATCH_SET, LATCH_CLEAR, SOFT_RESET} = 8'h40;
    {lock, prot, fail, latch, rst_en, busy} = 6'h0;
    repeat (10) @(posedge CLK);
    #1 RESETN = 1'h1;
    repeat (3) @(posedge CLK);
    rd("reset");
    $display("test reset done");
    foreach (corner[k]) begin
      ev(corner[k], 1'h1);
      rd("event");
    end
    $display("test events done");
    foreach (cases[k]) begin
      ev({2'h0, cases[k][24], 2'h0}, cases[k][28]);
      d = cases[k][15:8] | (8'($random(seed)) & (cases[k][23:16] == 8'h31 ? 8'hEF : 8'h7B));
      #1 host.frame({cases[k][23:16], d, 16'h0}, cases[k][7:0], rx);
      `CHK("no output", 1'h0, host.oe_any);
      wsr(cases[k][23:16], d, cases[k][7:0]);
      rd("write");
    end
    $display("test write done");
    #1 host.frame({fsr_pkg::OPC_READ_STATUS, 24'h0}, 13, rx);
    `CHK("abort", 2'h0, {SO_OE, SO});
    `CHK("abort bits", sr() >> 11, {11'h0, rx[4:0]});
    for (int k = 0; k < 12; k++) begin
      host.cpol = 1'(k);
      ev(5'($random(seed)), 1'($random(seed)));
      rd("random");
    end
    $display("test random done");
    close_out();
  end
endmodule
